// file: verilog/pmwc_ctrl.sv
`timescale 1ns/1ps
module pmwc_ctrl #(
  parameter int PA_W = 8,
  parameter int IRQ_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic halt_exec,
  input wire logic clr_wdt_exec,
  input wire logic wdt_overflow,
  input wire logic [IRQ_W-1:0] irq_req,
  input wire logic [IRQ_W-1:0] irq_en,
  input wire logic stack_full,
  input wire logic [PA_W-1:0] porta_pin,
  input wire pmwc_pkg::pmwc_osc_s osc_stable_pin,
  output pmwc_pkg::pmwc_state_e mode,
  output logic [2:0] sys_clk_sel,
  output logic fast_src,
  output logic slow_src,
  output logic fast_osc_en,
  output logic sub_osc_en,
  output logic cpu_run,
  output logic io_hold,
  output logic wdt_clear,
  output logic powerdown_flag,
  output logic wdt_timeout_flag,
  output logic pc_sp_reset,
  output logic resume_next,
  output logic irq_service,
  output logic [IRQ_W-1:0] irq_service_vec
);
  import pmwc_pkg::*;

  initial begin
    if (PA_W < 1 || PA_W > 16 || IRQ_W < 1 || IRQ_W > 16) begin
      $error("pmwc_ctrl: PA_W and IRQ_W must lie in 1..16");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pmwc_clkctl_s clkctl;
  logic [PA_W-1:0] porta_wake_enable;
  pmwc_state_e st;
  pmwc_state_e next_st;
  pmwc_osc_s osc_s1;
  pmwc_osc_s osc_s2;
  logic [PA_W-1:0] pa_s1;
  logic [PA_W-1:0] pa_s2;
  logic [PA_W-1:0] pa_prev;
  logic [IRQ_W-1:0] irq_armed;
  logic [IRQ_W-1:0] wake_irq_vec;
  logic wake_wdt;
  logic run_st;
  logic low_st;
  logic halt_take;
  logic slow_ok;
  logic fast_ok;
  logic need_ok;
  logic pa_wake;
  logic irq_wake;
  logic any_wake;
  logic wr_en;
  logic rd_setup;

  // Pick the stable flag of whichever source is selected
  function automatic logic src_stable(input logic sel_ext, input logic ext_ok,
                                      input logic int_ok);
    return sel_ext ? ext_ok : int_ok;
  endfunction

  assign run_st = (st == ST_FAST) || (st == ST_SLOW) || (st == ST_TO_SLOW) ||
                  (st == ST_TO_FAST);
  assign low_st = (st == ST_SLEEP) || (st == ST_IDLE_SLOW) || (st == ST_IDLE_BOTH) ||
                  (st == ST_IDLE_FAST);
  assign halt_take = halt_exec && run_st;
  assign slow_ok = src_stable(clkctl.slow_src_select, osc_s2.ext_slow_crystal,
                              osc_s2.int_slow_osc); // R2 R19
  assign fast_ok = src_stable(clkctl.fast_src_select, osc_s2.ext_fast_crystal,
                              osc_s2.int_fast_osc); // R4 R20
  assign need_ok = (sys_clk_sel == PMWC_SEL_SUB) ? slow_ok : fast_ok; // R21

  ////////////////////////////////////////////////////////////////////////////
  // Pins and oscillator flags cross in from outside, two flops each
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1 <= '0;
      osc_s2 <= '0;
      pa_s1 <= '1;
      pa_s2 <= '1;
      pa_prev <= '1;
    end else begin
      osc_s1 <= osc_stable_pin;
      osc_s2 <= osc_s1;
      pa_s1 <= porta_pin;
      pa_s2 <= pa_s1;
      pa_prev <= pa_s2;
    end
  end

  assign pa_wake = |(pa_prev & ~pa_s2 & porta_wake_enable); // R12 R15
  // Only requests that were clear at halt may wake
  assign irq_wake = |(irq_req & irq_armed); // R12 R18
  assign any_wake = pa_wake || irq_wake || wdt_overflow; // R12

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clkctl <= PMWC_CLKCTL_RST;
      porta_wake_enable <= '0;
    end else if (wr_en) begin
      if (paddr == PMWC_OFS_CLKCTL) begin
        clkctl <= pwdata[7:0] & PMWC_CLKCTL_WMASK; // R1 R3
      end
      if (paddr == PMWC_OFS_WAKEEN) begin
        porta_wake_enable <= pwdata[PA_W-1:0]; // R15
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= 32'h0000_0000;
      unique case (paddr)
        PMWC_OFS_CLKCTL: prdata[7:0] <= clkctl;
        PMWC_OFS_WAKEEN: prdata[PA_W-1:0] <= porta_wake_enable;
        PMWC_OFS_STATUS: begin
          prdata[PMWC_ST_PDF] <= powerdown_flag;
          prdata[PMWC_ST_TO] <= wdt_timeout_flag;
          prdata[PMWC_ST_STABLE +: 4] <= osc_s2; // R4
          prdata[PMWC_ST_STATE +: 9] <= st;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Unmapped addresses report an error; status is read-only
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      pslverr = !((paddr == PMWC_OFS_CLKCTL) || (paddr == PMWC_OFS_WAKEEN) ||
                  ((paddr == PMWC_OFS_STATUS) && !pwrite));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Mode sequencer
  always_comb begin
    next_st = st;
    unique case (st)
      ST_FAST: begin
        if (halt_take) begin
          next_st = ST_SLEEP;
        end else if (clkctl.sys_clk_select == PMWC_SEL_SUB) begin
          next_st = ST_TO_SLOW; // R1
        end
      end
      ST_TO_SLOW: begin
        if (halt_take) begin
          next_st = ST_SLEEP;
        end else if (clkctl.sys_clk_select != PMWC_SEL_SUB) begin
          next_st = ST_FAST;
        end else if (slow_ok) begin
          next_st = ST_SLOW; // R2
        end
      end
      ST_SLOW: begin
        if (halt_take) begin
          next_st = ST_SLEEP;
        end else if (clkctl.sys_clk_select != PMWC_SEL_SUB) begin
          next_st = ST_TO_FAST; // R3
        end
      end
      ST_TO_FAST: begin
        if (halt_take) begin
          next_st = ST_SLEEP;
        end else if (clkctl.sys_clk_select == PMWC_SEL_SUB) begin
          next_st = ST_SLOW;
        end else if (fast_ok) begin
          next_st = ST_FAST; // R4
        end
      end
      ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_BOTH, ST_IDLE_FAST: begin
        if (any_wake) begin
          next_st = ST_WAKE; // R12
        end
      end
      ST_WAKE: begin
        if (need_ok) begin
          next_st = (sys_clk_sel == PMWC_SEL_SUB) ? ST_SLOW : ST_FAST; // R21
        end
      end
      default: next_st = ST_FAST;
    endcase
    if (halt_take) begin
      unique case ({clkctl.fast_osc_keep_on, clkctl.slow_osc_keep_on})
        2'b00: next_st = ST_SLEEP; // R5
        2'b01: next_st = ST_IDLE_SLOW; // R6
        2'b11: next_st = ST_IDLE_BOTH; // R7
        2'b10: next_st = ST_IDLE_FAST; // R8
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= ST_FAST;
    end else begin
      st <= next_st;
    end
  end

  // Applied clock code changes only once the new source is usable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_sel <= 3'h0;
    end else if (st == ST_FAST && next_st == ST_FAST) begin
      sys_clk_sel <= clkctl.sys_clk_select; // R3
    end else if (st == ST_TO_SLOW && next_st == ST_SLOW) begin
      sys_clk_sel <= PMWC_SEL_SUB; // R1 R2
    end else if (st == ST_TO_FAST && next_st == ST_FAST) begin
      sys_clk_sel <= clkctl.sys_clk_select; // R3 R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt arming and wake cause capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_armed <= '0;
      wake_irq_vec <= '0;
      wake_wdt <= 1'b0;
    end else begin
      if (halt_take) begin
        irq_armed <= ~irq_req; // R18
        wake_irq_vec <= '0;
        wake_wdt <= 1'b0;
      end else if (low_st && any_wake) begin
        irq_armed <= '0;
        wake_irq_vec <= irq_req & irq_armed;
        wake_wdt <= wdt_overflow;
      end
    end
  end

  // Exit actions fire on the cycle execution restarts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_sp_reset <= 1'b0;
      resume_next <= 1'b0;
      irq_service <= 1'b0;
      irq_service_vec <= '0;
    end else begin
      pc_sp_reset <= 1'b0;
      resume_next <= 1'b0;
      irq_service <= 1'b0;
      irq_service_vec <= '0;
      if (st == ST_WAKE && need_ok) begin
        if (wake_wdt) begin
          pc_sp_reset <= 1'b1; // R14
        end else if (|(wake_irq_vec & irq_en) && !stack_full) begin
          irq_service <= 1'b1; // R17
          irq_service_vec <= wake_irq_vec & irq_en;
        end else begin
          resume_next <= 1'b1; // R15 R16
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power-down and timeout flags; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      powerdown_flag <= 1'b0;
    end else if (halt_take) begin
      powerdown_flag <= 1'b1; // R10
    end else if (clr_wdt_exec && run_st) begin
      powerdown_flag <= 1'b0; // R13
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_timeout_flag <= 1'b0;
    end else if (wdt_overflow) begin
      wdt_timeout_flag <= 1'b1; // R14
    end else if (halt_take) begin
      wdt_timeout_flag <= 1'b0; // R10
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdt_clear <= 1'b0;
    end else begin
      wdt_clear <= halt_take || (clr_wdt_exec && run_st); // R11
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock gating; internal slow oscillator for the watchdog is not ours
  assign mode = st;
  assign fast_src = clkctl.fast_src_select; // R20
  assign slow_src = clkctl.slow_src_select; // R19
  assign cpu_run = run_st; // R5 R21
  assign io_hold = !run_st; // R9
  assign fast_osc_en = (st == ST_FAST) || (st == ST_TO_SLOW) || (st == ST_TO_FAST) ||
                       (st == ST_IDLE_BOTH) || (st == ST_IDLE_FAST) ||
                       ((st == ST_WAKE) && (sys_clk_sel != PMWC_SEL_SUB)); // R4 R6 R8 R21
  assign sub_osc_en = (st == ST_SLOW) || (st == ST_TO_SLOW) || (st == ST_TO_FAST) ||
                      (st == ST_IDLE_SLOW) || (st == ST_IDLE_BOTH) ||
                      ((st == ST_WAKE) && (sys_clk_sel == PMWC_SEL_SUB)); // R2 R6 R7 R8

  ////////////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_halt_with(logic [1:0] k);
    halt_take && ({clkctl.fast_osc_keep_on, clkctl.slow_osc_keep_on} == k);
  endsequence

  sequence s_wake_exit;
    st == ST_WAKE && need_ok;
  endsequence

  a_sleep_entry: assert property (s_halt_with(2'b00) |=> // R5
    st == ST_SLEEP && !fast_osc_en && !sub_osc_en && !cpu_run)
    else $error("sleep entry wrong");

  a_idle_slow_entry: assert property (s_halt_with(2'b01) |=> // R6
    st == ST_IDLE_SLOW && !fast_osc_en && sub_osc_en)
    else $error("slow idle entry wrong");

  a_idle_both_entry: assert property (s_halt_with(2'b11) |=> // R7
    st == ST_IDLE_BOTH && fast_osc_en && sub_osc_en && !cpu_run)
    else $error("both-clock idle entry wrong");

  a_idle_fast_entry: assert property (s_halt_with(2'b10) |=> // R8
    st == ST_IDLE_FAST && fast_osc_en && !sub_osc_en)
    else $error("fast idle entry wrong");

  a_halt_flags: assert property (halt_take && !wdt_overflow |=> // R10
    powerdown_flag && !wdt_timeout_flag)
    else $error("halt flags wrong");

  a_wdt_cleared: assert property (halt_take |=> wdt_clear) // R11
    else $error("watchdog not cleared on halt");

  a_pdf_sticky: assert property (powerdown_flag && !clr_wdt_exec |=> powerdown_flag) // R13
    else $error("power-down flag lost");

  a_low_hold: assert property (low_st && !any_wake |=> st == $past(st) && io_hold) // R9 R18
    else $error("low power left without wake");

  // Bound covers the slowest oscillator settle plus the two sync flops
  a_wdt_wake: assert property (low_st && wdt_overflow |=> // R14
    wdt_timeout_flag && st == ST_WAKE ##[0:300] s_wake_exit)
    else $error("watchdog wake wrong");

  a_timeout_set: assert property (wdt_overflow |=> wdt_timeout_flag) // R14
    else $error("timeout flag not set");

  a_wake_stall: assert property (st == ST_WAKE && !need_ok |=> !cpu_run) // R21
    else $error("execution before clock stable");

  a_slow_wait: assert property (st == ST_TO_SLOW && !slow_ok && !halt_take &&
    clkctl.sys_clk_select == PMWC_SEL_SUB |=> st == ST_TO_SLOW && sys_clk_sel != PMWC_SEL_SUB) // R2
    else $error("slow switch before stable");

  a_irq_serve: assert property (s_wake_exit ##0 (!wake_wdt && |(wake_irq_vec & irq_en) &&
    !stack_full) |=> irq_service && !resume_next ##1 !irq_service) // R17
    else $error("interrupt not serviced");

  a_irq_defer: assert property (s_wake_exit ##0 (!wake_wdt && !(|(wake_irq_vec & irq_en) &&
    !stack_full)) |=> resume_next && !irq_service) // R16
    else $error("deferred wake wrong");

endmodule

// file: verilog/pmwc_pkg.sv
// Operation
// (R1) Select code 111 switches to sub-clock
// (R2) Slow switch waits for chosen slow oscillator
// (R3) Codes 000-110 pick fast clock divisors
// (R4) Fast oscillator restarts, stable before use
// (R5) Halt, both keep-on low: sleep
// (R6) Halt, slow keep-on only: slow idle
// (R7) Halt, both keep-on high: both-clock idle
// (R8) Halt, fast keep-on only: fast idle
// (R9) Low power holds memory, registers, ports
// (R10) Halt sets power-down, clears timeout flag
// (R11) Low-power entry clears watchdog counter
// (R12) Wake on port edge, interrupt, overflow
// (R13) Power-down flag cleared by reset, clear-watchdog
// (R14) Overflow in low power: timeout, PC/SP reset
// (R15) Per-pin port wake enables, resume after halt
// (R16) Disabled or stack-full interrupt: resume, pending
// (R17) Enabled interrupt with room: serviced on wake
// (R18) Already-pending interrupt cannot wake
// (R19) Slow select: 0 internal, 1 external crystal
// (R20) Fast select: 0 internal, 1 external crystal
// (R21) Wake holds execution until clock stable
package pmwc_pkg;

  localparam logic [7:0] PMWC_OFS_CLKCTL = 8'h00;
  localparam logic [7:0] PMWC_OFS_WAKEEN = 8'h04;
  localparam logic [7:0] PMWC_OFS_STATUS = 8'h08;

  localparam logic [2:0] PMWC_SEL_SUB = 3'h7;
  localparam logic [7:0] PMWC_CLKCTL_RST = 8'h00;
  localparam logic [7:0] PMWC_CLKCTL_WMASK = 8'hEF;

  localparam int PMWC_ST_PDF = 0;
  localparam int PMWC_ST_TO = 1;
  localparam int PMWC_ST_STABLE = 2;
  localparam int PMWC_ST_STATE = 8;

  typedef struct packed {
    logic [2:0] sys_clk_select;
    logic rsv;
    logic fast_src_select;
    logic slow_src_select;
    logic fast_osc_keep_on;
    logic slow_osc_keep_on;
  } pmwc_clkctl_s;

  typedef struct packed {
    logic ext_slow_crystal;
    logic int_slow_osc;
    logic ext_fast_crystal;
    logic int_fast_osc;
  } pmwc_osc_s;

  typedef enum logic [8:0] {
    ST_FAST = 9'h001,
    ST_TO_SLOW = 9'h002,
    ST_SLOW = 9'h004,
    ST_TO_FAST = 9'h008,
    ST_SLEEP = 9'h010,
    ST_IDLE_SLOW = 9'h020,
    ST_IDLE_BOTH = 9'h040,
    ST_IDLE_FAST = 9'h080,
    ST_WAKE = 9'h100
  } pmwc_state_e;

endpackage

// file: verif/pmwc_osc_model.sv
`timescale 1ns/1ps
module pmwc_osc_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fast_osc_en,
  input wire logic sub_osc_en,
  input wire logic fast_src,
  input wire logic slow_src,
  input wire logic [7:0] dly,
  output pmwc_pkg::pmwc_osc_s osc
);
  import pmwc_pkg::*;
  logic [7:0] fast_cnt;
  logic [7:0] slow_cnt;
  logic fast_ok;
  logic slow_ok;
  ////////////////////////////////////////////////////////////////////////////////
  // Stopping drops the flag at once; restart needs the full settle time again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_cnt <= 8'h00;
    end else if (!fast_osc_en) begin
      fast_cnt <= 8'h00;
    end else if (fast_cnt < dly) begin
      fast_cnt <= fast_cnt + 8'h01;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt <= 8'h00;
    end else if (!sub_osc_en) begin
      slow_cnt <= 8'h00;
    end else if (slow_cnt < dly) begin
      slow_cnt <= slow_cnt + 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Unselected source reads unstable, so a wrong pick stalls the switch
  assign fast_ok = fast_osc_en && (fast_cnt >= dly);
  assign slow_ok = sub_osc_en && (slow_cnt >= dly);
  assign osc.ext_slow_crystal = slow_ok & slow_src;
  assign osc.int_slow_osc = slow_ok & !slow_src;
  assign osc.ext_fast_crystal = fast_ok & fast_src;
  assign osc.int_fast_osc = fast_ok & !fast_src;
endmodule

// file: verif/power_mode_wakeup_control_tb_top.sv
`timescale 1ns/1ps
module power_mode_wakeup_control_tb_top;
  import pmwc_pkg::*;
  localparam logic [31:0] ALL = 32'hFFFF_FFFF;
  localparam logic [31:0] SMSK = 32'hFFFF_FFC3;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stack_full;
  logic halt_exec, clr_wdt_exec, wdt_overflow, fast_src, slow_src, fast_osc_en;
  logic sub_osc_en, cpu_run, io_hold, wdt_clear, powerdown_flag, wdt_timeout_flag;
  logic pc_sp_reset, resume_next, irq_service;
  logic [7:0] paddr, irq_req, irq_en, porta_pin, irq_service_vec, dly, m;
  logic [31:0] pwdata, prdata;
  logic [2:0] sys_clk_sel;
  pmwc_osc_s osc;
  pmwc_state_e mode;
  pmwc_state_e idle_of[4] = '{ST_SLEEP, ST_IDLE_SLOW, ST_IDLE_FAST, ST_IDLE_BOTH};
  logic [64:0] rq[$];
  logic [10:0] wq[$];
  logic [64:0] re;
  logic [10:0] we;
  int miscompares, cmp_count;
  ////////////////////////////////////////////////////////////////////////////////
  pmwc_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_exec(halt_exec), .clr_wdt_exec(clr_wdt_exec), .wdt_overflow(wdt_overflow),
    .irq_req(irq_req), .irq_en(irq_en), .stack_full(stack_full), .porta_pin(porta_pin),
    .osc_stable_pin(osc), .mode(mode), .sys_clk_sel(sys_clk_sel), .fast_src(fast_src),
    .slow_src(slow_src), .fast_osc_en(fast_osc_en), .sub_osc_en(sub_osc_en),
    .cpu_run(cpu_run), .io_hold(io_hold), .wdt_clear(wdt_clear),
    .powerdown_flag(powerdown_flag), .wdt_timeout_flag(wdt_timeout_flag),
    .pc_sp_reset(pc_sp_reset), .resume_next(resume_next), .irq_service(irq_service),
    .irq_service_vec(irq_service_vec)
  );
  pmwc_osc_model osc_src (
    .pclk(pclk), .presetn(presetn), .fast_osc_en(fast_osc_en), .sub_osc_en(sub_osc_en),
    .fast_src(fast_src), .slow_src(slow_src), .dly(dly), .osc(osc)
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick;
    @(posedge pclk);
    #1;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk,
                    input logic err);
    rq.push_back({err, mk, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_mode(input pmwc_state_e s);
    int n;
    n = 0;
    do begin
      tick();
      n++;
    end while (mode !== s && n < 400);
    check(64'(mode), 64'(s));
  endtask
  function automatic logic [31:0] st(input pmwc_state_e s, input logic to, input logic pd);
    return {15'h0, s, 6'h00, to, pd};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    if (halt_exec) halt_exec <= 1'b0;
    if (clr_wdt_exec) clr_wdt_exec <= 1'b0;
    if (wdt_overflow) wdt_overflow <= 1'b0;
  end
  always @(posedge pclk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      re = rq.pop_front();
      check({pslverr, prdata & re[63:32]}, {re[64], re[31:0]});
    end
  end
  // Any unexpected wake pulse pops an empty queue and fails
  always @(posedge pclk) begin
    if ((pc_sp_reset | irq_service | resume_next) === 1'b1) begin
      we = wq.pop_front();
      check({pc_sp_reset, irq_service, resume_next, irq_service ? irq_service_vec : 8'h00},
            we);
    end
  end
  initial begin
    #200000;
    miscompares++;
    final_report();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int c;
    logic [1:0] k;
    logic [7:0] v;
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, halt_exec, clr_wdt_exec, wdt_overflow, stack_full} = '0;
    {paddr, irq_req, irq_en, m} = '0;
    pwdata = '0;
    porta_pin = 8'hFF;
    dly = 8'd3;
    void'($urandom(45));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (10) tick();
    check({cpu_run, fast_osc_en, sub_osc_en, 9'(mode)}, {3'b110, ST_FAST});
    rd(PMWC_OFS_CLKCTL, 32'h0, ALL, 1'b0);
    rd(PMWC_OFS_WAKEEN, 32'h0, ALL, 1'b0);
    apb(1'b1, PMWC_OFS_STATUS, 32'h0000_0003);
    rd(PMWC_OFS_STATUS, st(ST_FAST, 1'b0, 1'b0), SMSK, 1'b0);
    rd(8'h0C, 32'h0, ALL, 1'b1);
    for (c = 0; c < 7; c++) begin
      v = {c[2:0], 5'($urandom)};
      apb(1'b1, PMWC_OFS_CLKCTL, {24'h0, v});
      tick();
      check({9'(mode), sys_clk_sel}, {ST_FAST, c[2:0]});
      rd(PMWC_OFS_CLKCTL, {24'h0, v & PMWC_CLKCTL_WMASK}, ALL, 1'b0);
    end
    // Kinds: overflow, port edge, served irq, disabled irq, stack-full irq
    for (i = 0; i < 5; i++) begin
      k = 2'(i);
      m = 8'h01 << ($urandom % 7);
      apb(1'b1, PMWC_OFS_CLKCTL, {30'h0, k});
      apb(1'b1, PMWC_OFS_WAKEEN, 32'h0000_0004);
      @(posedge pclk);
      irq_en <= (i == 3) ? 8'h00 : 8'h7F;
      stack_full <= (i == 4);
      irq_req <= 8'h80;
      @(posedge pclk);
      halt_exec <= 1'b1;
      tick();
      check(64'(mode), 64'(idle_of[k]));
      check({fast_osc_en, sub_osc_en, io_hold, wdt_clear, powerdown_flag, wdt_timeout_flag},
            {k, 4'b1110});
      @(posedge pclk);
      porta_pin[5] <= 1'b0;
      repeat (6) tick();
      check(64'(mode), 64'(idle_of[k]));
      rd(PMWC_OFS_STATUS, st(idle_of[k], 1'b0, 1'b1), SMSK, 1'b0);
      @(posedge pclk);
      case (i)
        0: begin
          wq.push_back(11'h400);
          wdt_overflow <= 1'b1;
        end
        1: begin
          wq.push_back(11'h100);
          porta_pin[2] <= 1'b0;
        end
        2: begin
          wq.push_back({3'b010, m});
          irq_req <= 8'h80 | m;
        end
        default: begin
          wq.push_back(11'h100);
          irq_req <= 8'h80 | m;
        end
      endcase
      wait_mode(ST_WAKE);
      check(64'(cpu_run), 64'(1'b0));
      wait_mode(ST_FAST);
      tick();
      check(64'(wq.size()), 64'(0));
      rd(PMWC_OFS_STATUS, st(ST_FAST, i == 0, 1'b1), SMSK, 1'b0);
      @(posedge pclk);
      irq_req <= 8'h00;
      porta_pin <= 8'hFF;
      stack_full <= 1'b0;
    end
    @(posedge pclk);
    clr_wdt_exec <= 1'b1;
    tick();
    check(64'(wdt_clear), 64'(1'b1));
    rd(PMWC_OFS_STATUS, st(ST_FAST, 1'b0, 1'b0), 32'hFFFF_FFC1, 1'b0);
    // Long settle so both transitional states can be seen
    @(posedge pclk);
    dly <= 8'd20 + 8'($urandom % 20);
    apb(1'b1, PMWC_OFS_CLKCTL, 32'h0000_00E4);
    tick();
    check({9'(mode), sys_clk_sel}, {ST_TO_SLOW, 3'h0});
    wait_mode(ST_SLOW);
    tick();
    check({slow_src, fast_osc_en, sys_clk_sel}, {2'b10, PMWC_SEL_SUB});
    apb(1'b1, PMWC_OFS_CLKCTL, 32'h0000_0068);
    tick();
    check(64'(mode), 64'(ST_TO_FAST));
    wait_mode(ST_FAST);
    tick();
    check({fast_src, sys_clk_sel}, {1'b1, 3'h3});
    repeat (4) @(posedge pclk);
    final_report();
  end
endmodule
